// ===== acir_regs.sv
// comparator register bank: input selection, status, flags, irq
// assumes an APB master on REF_CLK_I and comparator core signals
// synchronous to the same clock
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] sampled voltage: 0 divided A, 1 divided B
// [RULE2] bit 22 B reference; 21:16 A source
// [RULE3] minus code: dedicated, then shared bus pairs
// [RULE4] codes FB..FF pick internal special sources
// [RULE5] plus code uses the same map
// [RULE6] status bit 2 shows live bus conflict
// [RULE7] status bits show result and active, reset 0
// [RULE8] flag 1 set when warm-up ends
// [RULE9] flag 0 set on any result edge
// [RULE10] flag 2 set on bus conflict
// [RULE11] write one to set-alias sets flags
// [RULE12] write one to clear-alias clears flags
// [RULE13] read-clear option: clear-alias read clears flags
// [RULE14] enable register, one bit per source
// [RULE15] interrupt while flag and enable both set
module acir_regs (
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic [31:0]      PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        READ_CLEAR_EN_I,
	input  wire logic        COMPARATOR_RESULT_I,
	input  wire logic        COMPARATOR_ACTIVE_I,
	input  wire logic        WARMUP_DONE_I,
	input  wire logic        BUS_CONFLICT_I,
	output logic             SAMPLED_VOLTAGE_SOURCE_O,
	output logic             B_DIVIDER_REFERENCE_O,
	output logic [5:0]       A_DIVIDER_SOURCE_O,
	output logic             A_SOURCE_IS_SUPPLY_O,
	output logic [7:0]       MINUS_INPUT_SELECT_O,
	output logic [7:0]       PLUS_INPUT_SELECT_O,
	output logic [2:0]       MINUS_SRC_O,
	output logic [2:0]       MINUS_BUS_O,
	output logic             MINUS_BUS_Y_O,
	output logic [4:0]       MINUS_CHAN_O,
	output logic [2:0]       PLUS_SRC_O,
	output logic [2:0]       PLUS_BUS_O,
	output logic             PLUS_BUS_Y_O,
	output logic [4:0]       PLUS_CHAN_O,
	output logic             IRQ_O
);
	logic [31:0] input_sel_r;
	logic [2:0]  status_r;
	logic [2:0]  flags_r;
	logic [2:0]  flags_nxt;
	logic [2:0]  irq_en_r;
	logic        result_d_r;
	logic        warmup_d_r;
	logic        conflict_d_r;
	logic [2:0]  hw_set;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [31:0] rdata;

	acir_sel_if minus_sel ();
	acir_sel_if plus_sel ();

	function automatic logic hit(input logic [7:0] a,
				     input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	assign acc = PSEL_I && PENABLE_I;
	assign wr  = acc && PWRITE_I;
	assign rd  = acc && !PWRITE_I;
	// zero-wait slave: every access completes in its first access cycle
	assign PREADY_O = 1'b1;

	always_comb begin
		mapped = hit(PADDR_I, acir_pkg::ADDR_INPUT_SEL)
			|| hit(PADDR_I, acir_pkg::ADDR_STATUS)
			|| hit(PADDR_I, acir_pkg::ADDR_FLAGS)
			|| hit(PADDR_I, acir_pkg::ADDR_FLAG_SET)
			|| hit(PADDR_I, acir_pkg::ADDR_FLAG_CLR)
			|| hit(PADDR_I, acir_pkg::ADDR_IRQ_EN);
	end

	// unmapped addresses answer with an error instead of silent zero
	assign PSLVERR_O = acc && !mapped;

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			input_sel_r <= acir_pkg::RST_INPUT_SEL;
		end else if (wr && hit(PADDR_I, acir_pkg::ADDR_INPUT_SEL)) begin
			input_sel_r <= PWDATA_I & acir_pkg::INPUT_SEL_MASK;
		end
	end

	// core inputs are registered so status and edge share one sample
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			status_r     <= 3'h0;
			result_d_r   <= 1'b0;
			warmup_d_r   <= 1'b0;
			conflict_d_r <= 1'b0;
		end else begin
			status_r[acir_pkg::BIT_CONFLICT] <= BUS_CONFLICT_I; // [RULE6]
			status_r[1] <= COMPARATOR_RESULT_I; // [RULE7]
			status_r[0] <= COMPARATOR_ACTIVE_I; // [RULE7]
			result_d_r   <= status_r[1];
			warmup_d_r   <= WARMUP_DONE_I;
			conflict_d_r <= status_r[acir_pkg::BIT_CONFLICT];
		end
	end

	always_comb begin
		hw_set = 3'h0;
		hw_set[acir_pkg::BIT_EDGE]   = status_r[1] ^ result_d_r; // [RULE9]
		hw_set[acir_pkg::BIT_WARMUP] = WARMUP_DONE_I && !warmup_d_r; // [RULE8]
		// level-to-pulse so a held conflict does not refill a cleared flag
		hw_set[acir_pkg::BIT_CONFLICT] = status_r[acir_pkg::BIT_CONFLICT]
			&& !conflict_d_r; // [RULE10]
	end

	// clears applied first so a same-cycle hardware event wins
	always_comb begin
		flags_nxt = flags_r;
		if (wr && hit(PADDR_I, acir_pkg::ADDR_FLAG_CLR)) begin
			flags_nxt = flags_nxt & ~PWDATA_I[2:0]; // [RULE12]
		end
		if (rd && READ_CLEAR_EN_I
		    && hit(PADDR_I, acir_pkg::ADDR_FLAG_CLR)) begin
			// only what this read returned is cleared
			flags_nxt = flags_nxt & ~PRDATA_O[2:0]; // [RULE13]
		end
		if (wr && hit(PADDR_I, acir_pkg::ADDR_FLAG_SET)) begin
			flags_nxt = flags_nxt | PWDATA_I[2:0]; // [RULE11]
		end
		flags_nxt = flags_nxt | hw_set;
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			flags_r <= acir_pkg::RST_FLAGS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			irq_en_r <= acir_pkg::RST_IRQ_EN;
		end else if (wr && hit(PADDR_I, acir_pkg::ADDR_IRQ_EN)) begin
			irq_en_r <= PWDATA_I[2:0]; // [RULE14]
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ_O <= 1'b0;
		end else if (wr && hit(PADDR_I, acir_pkg::ADDR_IRQ_EN)) begin
			// enable written this edge counts at once, as the flags do
			IRQ_O <= |(flags_nxt & PWDATA_I[2:0]); // [RULE15]
		end else begin
			IRQ_O <= |(flags_nxt & irq_en_r); // [RULE15]
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (PADDR_I)
			acir_pkg::ADDR_INPUT_SEL: rdata = input_sel_r;
			acir_pkg::ADDR_STATUS:    rdata = {29'h0, status_r};
			acir_pkg::ADDR_FLAGS:     rdata = {29'h0, flags_r};
			acir_pkg::ADDR_FLAG_CLR: begin
				if (READ_CLEAR_EN_I) begin
					rdata = {29'h0, flags_r}; // [RULE13]
				end
			end
			acir_pkg::ADDR_IRQ_EN:    rdata = {29'h0, irq_en_r};
			default:                  rdata = 32'h0000_0000;
		endcase
	end

	// read data registered at setup so it stands through the access
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			PRDATA_O <= rdata;
		end
	end

	assign SAMPLED_VOLTAGE_SOURCE_O =
		input_sel_r[acir_pkg::POS_SAMPLED_V]; // [RULE1]
	assign B_DIVIDER_REFERENCE_O = input_sel_r[acir_pkg::POS_B_REF]; // [RULE2]
	assign A_DIVIDER_SOURCE_O = input_sel_r[acir_pkg::POS_A_SRC_HI:
					       acir_pkg::POS_A_SRC_LO]; // [RULE2]
	assign A_SOURCE_IS_SUPPLY_O = (A_DIVIDER_SOURCE_O
				       == acir_pkg::A_SRC_SUPPLY); // [RULE2]
	assign MINUS_INPUT_SELECT_O = input_sel_r[acir_pkg::POS_MINUS_HI:
						  acir_pkg::POS_MINUS_LO];
	assign PLUS_INPUT_SELECT_O = input_sel_r[acir_pkg::POS_PLUS_HI:
						 acir_pkg::POS_PLUS_LO];

	assign minus_sel.code = MINUS_INPUT_SELECT_O; // [RULE3]
	assign plus_sel.code  = PLUS_INPUT_SELECT_O; // [RULE5]

	acir_sel_decode u_minus_dec (
		.sel (minus_sel.dec)
	);

	acir_sel_decode u_plus_dec (
		.sel (plus_sel.dec)
	);

	assign MINUS_SRC_O   = minus_sel.src;
	assign MINUS_BUS_O   = minus_sel.bus_idx;
	assign MINUS_BUS_Y_O = minus_sel.bus_y;
	assign MINUS_CHAN_O  = minus_sel.chan;
	assign PLUS_SRC_O    = plus_sel.src;
	assign PLUS_BUS_O    = plus_sel.bus_idx;
	assign PLUS_BUS_Y_O  = plus_sel.bus_y;
	assign PLUS_CHAN_O   = plus_sel.chan;

	AST_EDGE_FLAG: assert property (@(posedge REF_CLK_I) // [RULE9]
		disable iff (RST_I)
		(status_r[1] != result_d_r) |=> flags_r[acir_pkg::BIT_EDGE])
		else $error("edge did not set flag 0");
	AST_WARMUP_FLAG: assert property (@(posedge REF_CLK_I) // [RULE8]
		disable iff (RST_I)
		$rose(WARMUP_DONE_I) |=> flags_r[acir_pkg::BIT_WARMUP])
		else $error("warm-up end did not set flag 1");
	AST_CONFLICT_FLAG: assert property (@(posedge REF_CLK_I) // [RULE10]
		disable iff (RST_I)
		$rose(BUS_CONFLICT_I)
		|=> ##1 flags_r[acir_pkg::BIT_CONFLICT])
		else $error("conflict did not set flag 2");
	AST_STATUS_CONFLICT: assert property (@(posedge REF_CLK_I) // [RULE6]
		disable iff (RST_I)
		##1 status_r[acir_pkg::BIT_CONFLICT] == $past(BUS_CONFLICT_I))
		else $error("status conflict bit wrong");
	AST_STATUS_RESULT: assert property (@(posedge REF_CLK_I) // [RULE7]
		disable iff (RST_I)
		##1 (status_r[1:0] == $past({COMPARATOR_RESULT_I,
					     COMPARATOR_ACTIVE_I})))
		else $error("status result or active bit wrong");
	AST_SET_ALIAS: assert property (@(posedge REF_CLK_I) // [RULE11]
		disable iff (RST_I)
		(wr && PADDR_I == acir_pkg::ADDR_FLAG_SET)
		|=> ((flags_r & $past(PWDATA_I[2:0]))
		     == $past(PWDATA_I[2:0])))
		else $error("set alias failed");
	AST_CLR_ALIAS: assert property (@(posedge REF_CLK_I) // [RULE12]
		disable iff (RST_I)
		(wr && PADDR_I == acir_pkg::ADDR_FLAG_CLR && hw_set == 3'h0)
		|=> ((flags_r & $past(PWDATA_I[2:0])) == 3'h0))
		else $error("clear alias failed");
	AST_READ_CLEAR: assert property (@(posedge REF_CLK_I) // [RULE13]
		disable iff (RST_I)
		(rd && READ_CLEAR_EN_I && PADDR_I == acir_pkg::ADDR_FLAG_CLR
		 && hw_set == 3'h0)
		|-> PRDATA_O[2:0] == $past(flags_r)
		##1 (flags_r & $past(PRDATA_O[2:0])) == 3'h0)
		else $error("read clear failed");
	AST_IRQ_EN_WRITE: assert property (@(posedge REF_CLK_I) // [RULE14]
		disable iff (RST_I)
		(wr && PADDR_I == acir_pkg::ADDR_IRQ_EN)
		|=> irq_en_r == $past(PWDATA_I[2:0]))
		else $error("enable register not written");
	AST_IRQ_LEVEL: assert property (@(posedge REF_CLK_I) // [RULE15]
		disable iff (RST_I)
		IRQ_O == |(flags_r & irq_en_r))
		else $error("interrupt level wrong");
	AST_SAMPLED_SEL: assert property (@(posedge REF_CLK_I) // [RULE1]
		disable iff (RST_I)
		(wr && PADDR_I == acir_pkg::ADDR_INPUT_SEL)
		|=> SAMPLED_VOLTAGE_SOURCE_O == $past(PWDATA_I[24]))
		else $error("sampled source select wrong");
	AST_SET_READ_ZERO: assert property (@(posedge REF_CLK_I) // [RULE11]
		disable iff (RST_I)
		(rd && PADDR_I == acir_pkg::ADDR_FLAG_SET)
		|-> PRDATA_O == 32'h0000_0000)
		else $error("set alias read not zero");
	AST_DEDIC_Y: assert property (@(posedge REF_CLK_I) // [RULE3]
		disable iff (RST_I)
		(MINUS_INPUT_SELECT_O[7:4] == 4'h1)
		|-> (MINUS_BUS_Y_O && MINUS_BUS_O == 3'h0
		     && MINUS_CHAN_O == {1'b0, MINUS_INPUT_SELECT_O[3:0]}))
		else $error("dedicated Y channel decode wrong");

	COV_EDGE_IRQ: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
		hw_set[acir_pkg::BIT_EDGE] && irq_en_r[acir_pkg::BIT_EDGE]
		##1 IRQ_O);
	COV_READ_CLEAR: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
		rd && READ_CLEAR_EN_I && PADDR_I == acir_pkg::ADDR_FLAG_CLR
		&& flags_r != 3'h0);
	COV_SET_CLR_RACE: cover property (@(posedge REF_CLK_I)
		disable iff (RST_I)
		wr && PADDR_I == acir_pkg::ADDR_FLAG_CLR && hw_set != 3'h0);
	COV_SHARED_BUS: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
		minus_sel.src == acir_pkg::SRC_BUS && minus_sel.bus_idx == 3'h4);
endmodule

// ===== acir_pkg.sv
// package: register map, field layout and codes of the comparator
// register bank; assumes a 32-bit APB with word-aligned byte addresses
package acir_pkg;
	localparam logic [7:0]  ADDR_INPUT_SEL = 8'h04;
	localparam logic [7:0]  ADDR_STATUS    = 8'h08;
	localparam logic [7:0]  ADDR_FLAGS     = 8'h0C;
	localparam logic [7:0]  ADDR_FLAG_SET  = 8'h10;
	localparam logic [7:0]  ADDR_FLAG_CLR  = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_EN    = 8'h18;
	localparam logic [31:0] RST_INPUT_SEL  = 32'h0000_0000;
	localparam logic [2:0]  RST_FLAGS      = 3'h0;
	localparam logic [2:0]  RST_IRQ_EN     = 3'h0;
	localparam int          POS_SAMPLED_V  = 24;
	localparam int          POS_B_REF      = 22;
	localparam int          POS_A_SRC_HI   = 21;
	localparam int          POS_A_SRC_LO   = 16;
	localparam int          POS_MINUS_HI   = 15;
	localparam int          POS_MINUS_LO   = 8;
	localparam int          POS_PLUS_HI    = 7;
	localparam int          POS_PLUS_LO    = 0;
	localparam logic [31:0] INPUT_SEL_MASK = 32'h017F_FFFF;
	localparam int          BIT_EDGE       = 0;
	localparam int          BIT_WARMUP     = 1;
	localparam int          BIT_CONFLICT   = 2;
	localparam int          NUM_SRC        = 3;
	localparam logic [7:0]  CODE_Y_DEDIC   = 8'h10;
	localparam logic [7:0]  CODE_SHARED    = 8'h20;
	localparam logic [7:0]  CODE_LAST_BUS  = 8'h9F;
	localparam logic [7:0]  CODE_VLP       = 8'hFB;
	localparam logic [7:0]  CODE_VB_DIV    = 8'hFC;
	localparam logic [7:0]  CODE_VA_DIV    = 8'hFD;
	localparam logic [7:0]  CODE_SUPPLY    = 8'hFE;
	localparam logic [7:0]  CODE_GROUND    = 8'hFF;
	localparam logic [5:0]  A_SRC_SUPPLY   = 6'h00;

	// analog source class chosen by an input select code
	typedef enum logic [2:0] {
		SRC_BUS,
		SRC_SAMPLED,
		SRC_DIV_B,
		SRC_DIV_A,
		SRC_SUPPLY,
		SRC_GROUND,
		SRC_NONE
	} acir_src_t;
endpackage

// ===== acir_sel_if.sv
// interface: one decoded input selection, shared by decoder and top
// assumes the top drives the code and reads the decode back
`timescale 1ns/1ns
interface acir_sel_if;
	logic [7:0]         code;
	acir_pkg::acir_src_t src;
	logic [2:0]         bus_idx;
	logic               bus_y;
	logic [4:0]         chan;
	modport ctrl (output code, input src, bus_idx, bus_y, chan);
	modport dec  (input code, output src, bus_idx, bus_y, chan);
endinterface

// ===== acir_sel_decode.sv
// input select decoder: code to bus pair, axis and channel
// assumes the code is steady register state; purely combinational
`timescale 1ns/1ns
module acir_sel_decode (
	acir_sel_if.dec sel
);
	always_comb begin
		sel.src     = acir_pkg::SRC_NONE;
		sel.bus_idx = 3'h0;
		sel.bus_y   = 1'b0;
		sel.chan    = 5'h00;
		if (sel.code < acir_pkg::CODE_Y_DEDIC) begin // [RULE3] [RULE5]
			sel.src  = acir_pkg::SRC_BUS;
			sel.chan = {1'b0, sel.code[3:0]};
		end else if (sel.code < acir_pkg::CODE_SHARED) begin // [RULE3]
			sel.src   = acir_pkg::SRC_BUS;
			sel.bus_y = 1'b1;
			sel.chan  = {1'b0, sel.code[3:0]};
		end else if (sel.code <= acir_pkg::CODE_LAST_BUS) begin // [RULE3]
			sel.src     = acir_pkg::SRC_BUS;
			sel.bus_idx = sel.code[7:5];
			sel.chan    = sel.code[4:0];
			// buses 1 and 3 put X on even channels, 2 and 4 put Y there
			sel.bus_y   = sel.code[0] ^ ~sel.code[5];
		end else begin
			case (sel.code) // [RULE4]
				acir_pkg::CODE_VLP:    sel.src = acir_pkg::SRC_SAMPLED;
				acir_pkg::CODE_VB_DIV: sel.src = acir_pkg::SRC_DIV_B;
				acir_pkg::CODE_VA_DIV: sel.src = acir_pkg::SRC_DIV_A;
				acir_pkg::CODE_SUPPLY: sel.src = acir_pkg::SRC_SUPPLY;
				acir_pkg::CODE_GROUND: sel.src = acir_pkg::SRC_GROUND;
				default:               sel.src = acir_pkg::SRC_NONE;
			endcase
		end
	end
endmodule

// ===== acir_core_model.sv
// partner model: comparator core and analog bus arbiter levels
// assumes the bench commands events on rising edges of clk_i
`timescale 1ns/1ns
module acir_core_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic flip_i,
	input  wire logic warm_i,
	input  wire logic conf_i,
	output logic      result_o,
	output logic      active_o,
	output logic      warmup_o,
	output logic      conflict_o
);
	// active only once warm, as the real core would be
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_o   <= 1'b0;
			active_o   <= 1'b0;
			warmup_o   <= 1'b0;
			conflict_o <= 1'b0;
		end else begin
			if (flip_i) begin
				result_o <= ~result_o;
			end
			warmup_o   <= warm_i;
			active_o   <= warm_i;
			conflict_o <= conf_i;
		end
	end
endmodule

// ===== testbench.sv
// self-checking bench of the comparator register bank
// assumes a zero-wait APB slave and the core model as far side
`timescale 1ns/1ns
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        rc_en = 1'b0;
	logic        flip = 1'b0;
	logic        warm = 1'b0;
	logic        conf = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, res, act, wu, cf;
	logic        sampled_low_power_voltage, bref, asup, my, py;
	logic [5:0]  asrc, aexp;
	logic [7:0]  msel, plsel, m, p, seed = 8'h25;
	logic [2:0]  msrc, mbus, psrc, pbus;
	logic [4:0]  mch, pch;
	logic [32:0] expq[$];
	logic [7:0]  bnd[11] = '{8'h0F, 8'h10, 8'h1F, 8'h20, 8'h9F, 8'hA0,
		8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;

	acir_regs i_dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .READ_CLEAR_EN_I(rc_en),
		.COMPARATOR_RESULT_I(res), .COMPARATOR_ACTIVE_I(act),
		.WARMUP_DONE_I(wu), .BUS_CONFLICT_I(cf),
		.SAMPLED_VOLTAGE_SOURCE_O(sampled_low_power_voltage), .B_DIVIDER_REFERENCE_O(bref),
		.A_DIVIDER_SOURCE_O(asrc), .A_SOURCE_IS_SUPPLY_O(asup),
		.MINUS_INPUT_SELECT_O(msel), .PLUS_INPUT_SELECT_O(plsel),
		.MINUS_SRC_O(msrc), .MINUS_BUS_O(mbus), .MINUS_BUS_Y_O(my),
		.MINUS_CHAN_O(mch), .PLUS_SRC_O(psrc), .PLUS_BUS_O(pbus),
		.PLUS_BUS_Y_O(py), .PLUS_CHAN_O(pch), .IRQ_O(irq));
	acir_core_model i_core (.clk_i(clk), .rst_i(rst), .flip_i(flip),
		.warm_i(warm), .conf_i(conf), .result_o(res), .active_o(act),
		.warmup_o(wu), .conflict_o(cf));

	always #50 clk = ~clk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// {source class, bus pair, y axis, channel}
	function automatic logic [11:0] dec(input logic [7:0] c);
		logic [2:0] s;
		s = (c <= 8'h9F) ? 3'h0 : (c >= 8'hFB) ? 3'(c - 8'hFA) : 3'h6;
		if (c < 8'h20) begin
			return {s, 3'h0, c[4], 1'b0, c[3:0]};
		end
		// pairs 2 and 4 start on Y, pairs 1 and 3 on X
		return {s, c[7:5], (c[7:5] == 3'h2 || c[7:5] == 3'h4) ^ c[0],
			c[4:0]};
	endfunction

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] exp);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		if (!wr) begin
			expq.push_back(exp);
		end
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {1'b0, d});
	endtask
	task automatic sel_is(input logic [7:0] c, input logic [11:0] got);
		logic [11:0] e;
		e = dec(c);
		if (e[11:9] == 3'h0) begin
			check({21'h0, got}, {21'h0, e});
		end else begin
			check({30'h0, got[11:9]}, {30'h0, e[11:9]});
		end
	endtask
	task automatic irq_is(input logic b);
		@(negedge clk);
		check({32'h0, irq}, {32'h0, b});
	endtask
	// one-cycle flip of the result, warm and conflict held as levels
	task automatic ev(input logic f, input logic w, input logic c);
		@(posedge clk);
		flip <= f;
		warm <= w;
		conf <= c;
		@(posedge clk);
		flip <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// read results are judged at the access edge, oldest note first
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check({pslverr, prdata}, expq.pop_front());
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(acir_pkg::ADDR_STATUS, 32'h0);
		rd(acir_pkg::ADDR_FLAGS, 32'h0);
		rd(acir_pkg::ADDR_IRQ_EN, 32'h0);
		wr(acir_pkg::ADDR_INPUT_SEL, 32'hFFFF_FFFF);
		rd(acir_pkg::ADDR_INPUT_SEL, acir_pkg::INPUT_SEL_MASK);
		@(negedge clk);
		check({24'h0, sampled_low_power_voltage, bref, asrc, asup}, {24'h0, 9'h1FE});
		for (int i = 0; i < 30; i++) begin
			seed = lfsr(seed);
			m = (i < 11) ? bnd[i] : seed;
			seed = lfsr(seed);
			p = (i < 11) ? bnd[10 - i] : seed;
			aexp = seed[5:0] & {6{i[0]}};
			wr(acir_pkg::ADDR_INPUT_SEL, {7'h0, seed[0], 1'b0, seed[1],
				aexp, m, p});
			@(negedge clk);
			check({31'h0, sampled_low_power_voltage, asup}, {31'h0, seed[0], aexp == 6'h00});
			check({25'h0, bref, asrc}, {25'h0, seed[1], aexp});
			check({17'h0, msel, plsel}, {17'h0, m, p});
			sel_is(m, {msrc, mbus, my, mch});
			sel_is(p, {psrc, pbus, py, pch});
		end
		wr(acir_pkg::ADDR_IRQ_EN, 32'h7);
		ev(1'b1, 1'b0, 1'b0);
		rd(acir_pkg::ADDR_STATUS, 32'h2);
		rd(acir_pkg::ADDR_FLAGS, 32'h1);
		irq_is(1'b1);
		wr(acir_pkg::ADDR_FLAG_CLR, 32'h7);
		ev(1'b1, 1'b1, 1'b0);
		rd(acir_pkg::ADDR_STATUS, 32'h1);
		rd(acir_pkg::ADDR_FLAGS, 32'h3);
		ev(1'b0, 1'b1, 1'b1);
		rd(acir_pkg::ADDR_STATUS, 32'h5);
		rd(acir_pkg::ADDR_FLAGS, 32'h7);
		ev(1'b0, 1'b1, 1'b0);
		rd(acir_pkg::ADDR_STATUS, 32'h1);
		wr(acir_pkg::ADDR_FLAG_CLR, 32'h7);
		rd(acir_pkg::ADDR_FLAGS, 32'h0);
		irq_is(1'b0);
		wr(acir_pkg::ADDR_FLAG_SET, 32'h5);
		wr(acir_pkg::ADDR_FLAG_SET, 32'h0);
		rd(acir_pkg::ADDR_FLAGS, 32'h5);
		wr(acir_pkg::ADDR_FLAG_CLR, 32'h4);
		wr(acir_pkg::ADDR_FLAGS, 32'hFF);
		wr(acir_pkg::ADDR_STATUS, 32'hFF);
		rd(acir_pkg::ADDR_FLAGS, 32'h1);
		rd(acir_pkg::ADDR_STATUS, 32'h1);
		wr(acir_pkg::ADDR_IRQ_EN, 32'h2);
		irq_is(1'b0);
		wr(acir_pkg::ADDR_FLAG_SET, 32'h2);
		irq_is(1'b1);
		rd(acir_pkg::ADDR_IRQ_EN, 32'h2);
		rd(acir_pkg::ADDR_FLAG_CLR, 32'h0);
		@(posedge clk);
		rc_en <= 1'b1;
		rd(acir_pkg::ADDR_FLAG_CLR, 32'h3);
		rd(acir_pkg::ADDR_FLAGS, 32'h0);
		irq_is(1'b0);
		rd(acir_pkg::ADDR_FLAG_SET, 32'h0);
		apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule
